// file: rtl/swm_pkg.sv
// Package: command codes, field layout, reset values, status bit positions
package swm_pkg;
    localparam int SWM_WORD_BITS = 24;
    localparam int SWM_NPROG     = 8;
    localparam int SWM_NGND      = 14;
    localparam int SWM_NSW       = 22;
    localparam logic [4:0] SWM_BITCNT_LAST = 5'h17;
    // Command codes in bits 23:16
    localparam logic [7:0] SWM_CMD_SETTINGS = 8'h01;
    localparam logic [7:0] SWM_CMD_WAKE_SP  = 8'h02;
    localparam logic [7:0] SWM_CMD_WAKE_SG  = 8'h03;
    localparam int SWM_CMD_HI = 23;
    localparam int SWM_CMD_LO = 16;
    // Status word bit positions
    localparam int SWM_ST_THERM = 23;
    localparam int SWM_ST_RESET = 22;
    // Defaults after reset
    localparam logic [7:0]  SWM_TYPE_RST     = 8'hff;
    localparam logic [7:0]  SWM_WAKE_SP_RST  = 8'hff;
    localparam logic [13:0] SWM_WAKE_SG_RST  = 14'h3fff;
    localparam logic [7:0]  SWM_WET_RST      = 8'hff;
    localparam int          SWM_WET_TIME_MS  = 20;
    localparam logic [4:0]  SWM_ANALOG_RST   = 5'h00;

    typedef enum logic {SWM_NORMAL, SWM_SLEEP} swm_mode_t;

    // Link pins as seen inside the device
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } swm_spi_in_t;

    typedef struct packed {
        logic so;
        logic so_oe_n;
    } swm_spi_out_t;
endpackage

// file: rtl/swm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module swm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] stage1;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/swm_spi_ctrl.sv
// Switch monitor serial control: link shifter, command decode, interrupt, mode
// What this block does
// - A frame is 24 clocks under low chip select: one command, one status.
// - Every reply carries switch states, reset flag and thermal flag.
// - Switch states are captured into the out shifter at chip select fall.
// - Battery supply arrival resets the device and starts Normal mode.
// - Resets restore battery type, all wake enables, wetting timer, defaults.
// - Bit 22 reports reset until the next chip select rise.
// - Normal mode entered on supply, enabled change, wake, int or cs fall.
// - Register writes accepted only in Normal mode with logic supply.
// - Logic supply loss keeps mode; sleep ends on wake, change or timer.
// - Without logic supply, no link traffic, int and cs wakes ignored.
// - Chip select rise releases interrupt unless a change came during frame.
// - Code 01 loads the eight input types from bits 7 to 0.
// - A closed programmable input always reports as one.
// - Programmable input polarity follows its battery or ground type.
// - Ground-only inputs read closed when comparator shows below threshold.
// - Disabled enable bit blocks interrupt and wake from that input.
// - Enabled bit lets a change raise interrupt in Normal mode and wake from sleep.
// - Code 02 loads programmable enables, code 03 ground enables.
// - Thermal flag is monitored in Normal mode and sent every reply.
// - Sample input on falling clock, shift out on rising, MSB first.
// - Open switch reports zero, closed switch reports one.
// - Command acts at chip select rise; output tri-stated while it is high.
`timescale 1ns/1ns
`default_nettype none
module swm_spi_ctrl
    import swm_pkg::*;
(
    // Clock and reset (reset stands for battery power-on)
    input  wire logic                     i_mclk,
    input  wire logic                     i_resetn,
    // Serial link pins
    input  wire swm_pkg::swm_spi_in_t     i_spi,
    output var swm_pkg::swm_spi_out_t     o_spi,
    // Comparator outputs, one means above threshold
    input  wire logic [7:0]               i_prog_above,
    input  wire logic [13:0]              i_gnd_above,
    // Supply, wake and timer sources
    input  wire logic                     i_logic_supply,
    input  wire logic                     i_wake_n,
    input  wire logic                     i_int_pin,
    input  wire logic                     i_sleep_req,
    input  wire logic                     i_int_timer_exp,
    input  wire logic                     i_over_temp,
    // Interrupt, open drain: enable low while pulling low
    output logic                          o_int_n,
    output logic                          o_int_oe_n,
    // Mode and configuration to analog side
    output logic                          o_normal,
    output logic [7:0]                    o_prog_type,
    output logic [21:0]                   o_wake_en,
    output logic [21:0]                   o_wet_timer_en,
    output logic [21:0]                   o_tristate,
    output logic [4:0]                    o_analog_sel
);
    import swm_pkg::*;

    logic [2:0]  spi_s;
    logic [7:0]  prog_s;
    logic [13:0] gnd_s;
    logic [4:0]  misc_s;
    logic        cs_n_q, sclk_q, wake_q, int_q;
    logic [21:0] sw_q;
    logic [23:0] rx_sr, tx_sr;
    logic [4:0]  bit_cnt;
    logic        frame_full;
    logic        reset_flag;
    logic        therm;
    logic        int_act;
    logic        change_in_frame;
    swm_mode_t   mode;
    logic [21:0] sw_now;
    logic [21:0] sw_chg;
    logic        en_change;
    logic        cs_fall, cs_rise, sclk_rise, sclk_fall;
    logic        wake_fall, int_fall;
    logic        link_ok;
    logic        write_ok;
    logic        rst_cmd;
    logic [1:0]  warm;

    // Every pin except i_sleep_req and i_resetn passes two flops before use
    swm_sync #(.W(3)) u_sync_spi (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({~i_spi.cs_n, i_spi.sclk, i_spi.si}),
        .o_sync   (spi_s)
    );
    swm_sync #(.W(8)) u_sync_prog (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  (i_prog_above),
        .o_sync   (prog_s)
    );
    swm_sync #(.W(14)) u_sync_gnd (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  (i_gnd_above),
        .o_sync   (gnd_s)
    );
    swm_sync #(.W(5)) u_sync_misc (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({i_logic_supply, ~i_wake_n, ~i_int_pin,
                    i_int_timer_exp, i_over_temp}),
        .o_sync   (misc_s)
    );
    // Chip select and wake/int are synced inverted so reset reads idle-high

    assign sw_now = {~gnd_s, prog_s ~^ o_prog_type};

    assign link_ok   = misc_s[4];
    assign cs_fall   = link_ok && spi_s[2] && cs_n_q;
    assign cs_rise   = !spi_s[2] && !cs_n_q;
    assign sclk_rise = spi_s[1] && !sclk_q && !cs_n_q;
    assign sclk_fall = !spi_s[1] && sclk_q && !cs_n_q;
    assign wake_fall = misc_s[3] && !wake_q;
    assign int_fall  = misc_s[2] && !int_q;
    assign sw_chg    = sw_now ^ sw_q;
    assign en_change = (warm == 2'h3) && |(sw_chg & o_wake_en);
    assign frame_full = (bit_cnt == SWM_BITCNT_LAST + 5'h01);
    // writes only in Normal with supply
    assign write_ok  = cs_rise && frame_full && mode == SWM_NORMAL
                       && link_ok;
    assign rst_cmd   = 1'b0;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            wake_q <= 1'b0;
            int_q  <= 1'b0;
            sw_q   <= '0;
        end else begin
            cs_n_q <= !spi_s[2];
            sclk_q <= spi_s[1];
            wake_q <= misc_s[3];
            int_q  <= misc_s[2];
            sw_q   <= sw_now;
        end
    end

    // Reset values of the synchronisers must not look like switch changes
    always_ff @(posedge i_mclk) begin
        if (!i_resetn)
            warm <= '0;
        else if (warm != 2'h3)
            warm <= warm + 2'h1;
    end

    // sample falling, shift rising, MSB first
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_sr   <= '0;
            bit_cnt <= '0;
        end else if (cs_fall) begin
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            rx_sr <= {rx_sr[22:0], spi_s[0]};
            // Saturates at 31 so an over-long frame is refused
            if (bit_cnt != 5'h1f)
                bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tx_sr <= '0;
        end else if (cs_fall) begin
            tx_sr <= {therm, reset_flag, sw_now};
        end else if (sclk_rise) begin
            tx_sr <= {tx_sr[22:0], 1'b0};
        end
    end

    // First rising edge presents bit 23; before it the output is held low
    logic so_q;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn)
            so_q <= 1'b0;
        else if (cs_fall)
            so_q <= 1'b0;
        else if (sclk_rise)
            so_q <= tx_sr[23];
    end
    // output off while chip select high
    assign o_spi = '{so: so_q, so_oe_n: cs_n_q || !link_ok};

    // reset flag cleared on chip select rise
    always_ff @(posedge i_mclk) begin
        if (!i_resetn)
            reset_flag <= 1'b1;
        else if (cs_rise)
            reset_flag <= 1'b0;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn)
            therm <= 1'b0;
        else if (mode == SWM_NORMAL)
            therm <= misc_s[0];
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mode <= SWM_NORMAL;
        end else if (mode == SWM_SLEEP) begin
            if (en_change || wake_fall || misc_s[1] || cs_fall
                || (int_fall && link_ok && !misc_s[3]))
                mode <= SWM_NORMAL;
        end else if (i_sleep_req && !cs_n_q == 1'b0) begin
            mode <= SWM_SLEEP;
        end
    end
    assign o_normal = (mode == SWM_NORMAL);

    // release at rise unless change during frame
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            int_act         <= 1'b0;
            change_in_frame <= 1'b0;
        end else begin
            if (cs_fall)
                change_in_frame <= 1'b0;
            else if (!cs_n_q && en_change)
                change_in_frame <= 1'b1;
            if (mode == SWM_NORMAL && en_change)
                int_act <= 1'b1;
            else if (cs_rise && !change_in_frame)
                int_act <= 1'b0;
        end
    end
    assign o_int_n    = 1'b0;
    assign o_int_oe_n = !int_act;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn || rst_cmd) begin
            o_prog_type    <= SWM_TYPE_RST;
            o_wake_en      <= {SWM_WAKE_SG_RST, SWM_WAKE_SP_RST};
            o_wet_timer_en <= {SWM_NSW{1'b1}};
            o_tristate     <= {SWM_NSW{1'b1}};
            o_analog_sel   <= SWM_ANALOG_RST;
        end else if (write_ok) begin
            unique case (rx_sr[SWM_CMD_HI:SWM_CMD_LO])
                SWM_CMD_SETTINGS: o_prog_type <= rx_sr[7:0];
                SWM_CMD_WAKE_SP:  o_wake_en[7:0] <= rx_sr[7:0];
                SWM_CMD_WAKE_SG:  o_wake_en[21:8] <= rx_sr[13:0];
                default: ;
            endcase
        end
    end

    // flag gone the cycle after chip select rise
    property p_reset_flag_clear;
        @(posedge i_mclk) disable iff (!i_resetn) cs_rise |=> !reset_flag;
    endproperty
    a_reset_flag_clear: assert property (p_reset_flag_clear)
        else $error("reset flag not cleared");
    property p_so_off;
        @(posedge i_mclk) disable iff (!i_resetn) cs_rise |=> o_spi.so_oe_n;
    endproperty
    a_so_off: assert property (p_so_off)
        else $error("output driven while deselected");
    property p_int_hold;
        @(posedge i_mclk) disable iff (!i_resetn)
        cs_rise && change_in_frame && int_act |=> !o_int_oe_n;
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt dropped despite change");
    property p_no_write_sleep;
        @(posedge i_mclk) disable iff (!i_resetn)
        mode == SWM_SLEEP |=> $stable(o_prog_type);
    endproperty
    a_no_write_sleep: assert property (p_no_write_sleep)
        else $error("write in sleep");
    property p_settings;
        @(posedge i_mclk) disable iff (!i_resetn)
        write_ok && rx_sr[SWM_CMD_HI:SWM_CMD_LO] == SWM_CMD_SETTINGS
        |=> o_prog_type == $past(rx_sr[7:0]);
    endproperty
    a_settings: assert property (p_settings)
        else $error("settings not loaded");
    property p_capture;
        @(posedge i_mclk) disable iff (!i_resetn)
        cs_fall |=> tx_sr[21:0] == $past(sw_now);
    endproperty
    a_capture: assert property (p_capture)
        else $error("switch capture wrong");
    property p_wake;
        @(posedge i_mclk) disable iff (!i_resetn)
        mode == SWM_SLEEP && wake_fall |=> mode == SWM_NORMAL;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake");
    property p_unknown;
        @(posedge i_mclk) disable iff (!i_resetn)
        write_ok && rx_sr[SWM_CMD_HI:SWM_CMD_LO] > SWM_CMD_WAKE_SG
        |=> $stable(o_wake_en);
    endproperty
    a_unknown: assert property (p_unknown)
        else $error("unknown command changed state");
endmodule
`default_nettype wire

// file: dv/swm_host.sv
// Host master model: drives frames on the serial link, collects replies
`timescale 1ns/1ns
`default_nettype none
module swm_host
    import swm_pkg::*;
(
    // Link pins toward the device
    output var swm_pkg::swm_spi_in_t   o_spi,
    // Reply from the device
    input  wire swm_pkg::swm_spi_out_t i_spi
);
    initial o_spi = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};

    // full frame, 3.125 MHz, sclk low at cs edges
    // n of 48 sends cmd twice and keeps only the last 24 reply bits
    task automatic xfer(input logic [23:0] cmd, input int n,
                        output logic [23:0] rx);
        rx = 24'h000000;
        // Step off the device clock edge so no pin change races it
        #1;
        o_spi.cs_n = 1'b0;
        #320;
        for (int i = n - 1; i >= 0; i--) begin
            o_spi.sclk = 1'b1;
            o_spi.si = cmd[i % 24];
            #160;
            rx = {rx[22:0], i_spi.so};
            o_spi.sclk = 1'b0;
            #160;
        end
        o_spi.cs_n = 1'b1;
        // Idle data line shows no stale bit
        o_spi.si = ~o_spi.si;
        #320;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Testbench: reference model and scenarios for the switch monitor link
`timescale 1ns/1ns
`default_nettype none
module tb;
    import swm_pkg::*;
    logic         i_mclk = 1'b0;
    logic         i_resetn = 1'b0;
    swm_spi_in_t  spi_in;
    swm_spi_out_t spi_out;
    logic [7:0]   prog_above = 8'h00;
    logic [13:0]  gnd_above = 14'h0000;
    logic         supply = 1'b1;
    logic         wake_n = 1'b1;
    logic         sleep_req = 1'b0;
    logic         tmr_exp = 1'b0;
    logic         hot = 1'b0;
    logic         int_n;
    logic         int_oe_n;
    logic         normal;
    logic         int_wire;
    logic [7:0]   prog_type;
    logic [21:0]  wake_en;
    logic [21:0]  wet_en;
    logic [21:0]  tri_en;
    logic [4:0]   analog_sel;
    logic [7:0]   m_type = SWM_TYPE_RST;
    logic [21:0]  m_wen = {SWM_WAKE_SG_RST, SWM_WAKE_SP_RST};
    logic         m_rst = 1'b1;
    logic         m_norm = 1'b1;
    logic [7:0]   codes [4];
    int           bad_count = 0;
    int           checks_done = 0;
    int           seed = 32'h996200ff;

    always #20 i_mclk = ~i_mclk;
    // Open-drain interrupt wire with pull-up
    assign int_wire = int_oe_n ? 1'b1 : int_n;

    swm_spi_ctrl u_swm_spi_ctrl (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_spi(spi_in),
        .o_spi(spi_out), .i_prog_above(prog_above),
        .i_gnd_above(gnd_above), .i_logic_supply(supply),
        .i_wake_n(wake_n), .i_int_pin(int_wire), .i_sleep_req(sleep_req),
        .i_int_timer_exp(tmr_exp), .i_over_temp(hot), .o_int_n(int_n),
        .o_int_oe_n(int_oe_n), .o_normal(normal), .o_prog_type(prog_type),
        .o_wake_en(wake_en), .o_wet_timer_en(wet_en), .o_tristate(tri_en),
        .o_analog_sel(analog_sel)
    );
    swm_host u_swm_host (.o_spi(spi_in), .i_spi(spi_out));

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic cfg_chk();
        cmp(24'(prog_type), 24'(m_type), "type");
        cmp(24'(wake_en), 24'(m_wen), "wake en");
        cmp(24'(normal), 24'(m_norm), "mode");
        cmp(24'(spi_out.so_oe_n), 24'h000001, "so idle");
    endtask

    task automatic frame(input logic [23:0] c, input int n);
        logic [23:0] e;
        logic [23:0] got;
        e = {hot, m_rst, ~gnd_above, m_type ~^ prog_above};
        u_swm_host.xfer(c, n, got);
        if (n == 24 && supply) begin
            cmp(got, e, "status");
            case (c[SWM_CMD_HI:SWM_CMD_LO])
                SWM_CMD_SETTINGS: m_type = c[7:0];
                SWM_CMD_WAKE_SP: m_wen[7:0] = c[7:0];
                SWM_CMD_WAKE_SG: m_wen[21:8] = c[13:0];
                default: ;
            endcase
        end
        // Any chip select rise clears the reset flag
        m_rst = 1'b0;
        cfg_chk();
    endtask

    task automatic wait_int(input logic exp);
        for (int k = 0; k < 50 && int_oe_n !== exp; k++) @(posedge i_mclk);
        cmp(24'(int_oe_n), 24'(exp), "int");
        if (int_oe_n !== exp) print_verdict();
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        codes = '{SWM_CMD_SETTINGS, SWM_CMD_WAKE_SP, SWM_CMD_WAKE_SG, 8'he5};
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        cmp(24'(wet_en), 24'h3fffff, "wet");
        cmp(24'(tri_en), 24'h3fffff, "tri");
        cmp(24'(analog_sel), 24'(SWM_ANALOG_RST), "analog");
        cfg_chk();
        cmp(24'(int_oe_n), 24'h000001, "int rst");
        for (int i = 0; i < 12; i++) begin
            @(posedge i_mclk);
            prog_above <= 8'($random(seed));
            gnd_above <= 14'($random(seed));
            hot <= 1'($random(seed));
            // Let the pin synchronisers and thermal flop settle first
            repeat (4) @(posedge i_mclk);
            frame({codes[i % 4], 16'($random(seed))}, 24);
        end
        frame({SWM_CMD_SETTINGS, 16'h0055}, 23);
        frame({SWM_CMD_SETTINGS, 16'h00aa}, 25);
        frame({SWM_CMD_WAKE_SP, 16'h00fe}, 24);
        frame({SWM_CMD_WAKE_SG, 16'h3fff}, 24);
        frame(24'h000000, 24);
        cmp(24'(int_oe_n), 24'h000001, "int clr");
        @(posedge i_mclk);
        prog_above <= prog_above ^ 8'h01;
        repeat (20) @(posedge i_mclk);
        cmp(24'(int_oe_n), 24'h000001, "int masked");
        gnd_above <= gnd_above ^ 14'h0001;
        wait_int(1'b0);
        fork
            frame(24'h000000, 24);
            begin
                #3000;
                @(posedge i_mclk);
                gnd_above <= gnd_above ^ 14'h0002;
            end
        join
        cmp(24'(int_oe_n), 24'h000000, "int held");
        frame(24'h000000, 24);
        cmp(24'(int_oe_n), 24'h000001, "int clr2");
        @(posedge i_mclk);
        supply <= 1'b0;
        @(posedge i_mclk);
        frame({SWM_CMD_SETTINGS, 16'h0000}, 24);
        @(posedge i_mclk);
        sleep_req <= 1'b1;
        @(posedge i_mclk);
        sleep_req <= 1'b0;
        m_norm = 1'b0;
        repeat (10) @(posedge i_mclk);
        frame({SWM_CMD_SETTINGS, 16'h0000}, 24);
        @(posedge i_mclk);
        wake_n <= 1'b0;
        m_norm = 1'b1;
        repeat (10) @(posedge i_mclk);
        cfg_chk();
        wake_n <= 1'b1;
        supply <= 1'b1;
        repeat (4) @(posedge i_mclk);
        sleep_req <= 1'b1;
        @(posedge i_mclk);
        sleep_req <= 1'b0;
        repeat (4) @(posedge i_mclk);
        cmp(24'(normal), 24'h000000, "asleep");
        tmr_exp <= 1'b1;
        repeat (4) @(posedge i_mclk);
        tmr_exp <= 1'b0;
        cmp(24'(normal), 24'h000001, "timer wake");
        repeat (2) @(posedge i_mclk);
        frame({SWM_CMD_SETTINGS, 16'h0033}, 24);
        print_verdict();
    end
endmodule
`default_nettype wire
